// *** design/hsl_map.svh ***
// register map, field positions and reset values of the strap latch
`ifndef HSL_MAP_SVH
`define HSL_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define HSL_STRAP_STATUS_OFS 8'h00
`define HSL_VPHY_SPECIAL_CTL_OFS 8'h04
`define HSL_MODE_STATUS_OFS 8'h08

// ----------------------------------------
// strap status fields
// ----------------------------------------
`define HSL_ST_LED_POL_LSB 0
`define HSL_ST_MGMT_LSB 8
`define HSL_ST_IFACE_LSB 12
`define HSL_ST_PINS_LSB 16
`define HSL_ST_ADDR_BIT 20
`define HSL_ST_PROM_BIT 21
`define HSL_ST_XOVER1_BIT 22
`define HSL_ST_XOVER2_BIT 23

// ----------------------------------------
// virtual phy special control fields
// ----------------------------------------
`define HSL_VS_REFCLK_DIR_BIT 0
`define HSL_VS_CLK_DRIVE_BIT 1
`define HSL_VS_HIRATE_BIT 2

// ----------------------------------------
// mode status fields
// ----------------------------------------
`define HSL_MS_CAPTURING_BIT 0
`define HSL_MS_CAPTURED_BIT 1
`define HSL_MS_MGMT_RSVD_BIT 2
`define HSL_MS_IFACE_RSVD_BIT 3

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define HSL_MGMT_EXT_MDIO 2'h1
`define HSL_MGMT_I2C 2'h2
`define HSL_IFACE_MII_MAC 2'h0
`define HSL_IFACE_MII_PHY 2'h1
`define HSL_IFACE_RMII_PHY 2'h2
`define HSL_IFACE_RSVD 2'h3
`define HSL_PINS_ALL_ONES 3'h7
`define HSL_RESP_OKAY 2'h0
`define HSL_RESP_DECERR 2'h3
`define HSL_DATA_ZERO 32'h0000_0000

`endif

// *** design/hsl_pin_if.sv ***
// synchronised strap pins and reset requests between pin stage and core
`timescale 1ns/10ps
`default_nettype none

interface hsl_pin_if;
	logic [5:0] led_pins;
	logic [2:0] mode_pins;
	logic ext_rst_active;
	logic por_active;

	modport sync_side (output led_pins, output mode_pins, output ext_rst_active,
		output por_active);
	modport core_side (input led_pins, input mode_pins, input ext_rst_active,
		input por_active);
endinterface

`default_nettype wire

// *** design/hsl_pin_sync.sv ***
// two-stage synchronisers for strap pins and reset requests
`timescale 1ns/10ps
`default_nettype none

module hsl_pin_sync
	import hsl_pkg::*;
#(
	parameter int NUM_BITS = 11
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [NUM_BITS-1:0] raw_in,
	hsl_pin_if.sync_side pins
);

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (NUM_BITS != 11) begin : g_bad_width
		$error("hsl_pin_sync needs exactly 11 bits");
	end

	// bit 9 is the active-low reset pin: it rests high so sys_rst never
	// looks like a pin reset and triggers a capture
	localparam logic [NUM_BITS-1:0] RST_VAL = 11'h200;

	logic [NUM_BITS-1:0] meta_ff;
	logic [NUM_BITS-1:0] sync_ff;

	// ----------------------------------------
	// per-bit synchroniser
	// ----------------------------------------
	for (genvar i = 0; i < NUM_BITS; i++) begin : g_sync
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				meta_ff[i] <= RST_VAL[i];
				sync_ff[i] <= RST_VAL[i];
			end else begin
				meta_ff[i] <= raw_in[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign pins.led_pins = sync_ff[5:0];
	assign pins.mode_pins = sync_ff[8:6];
	assign pins.ext_rst_active = ~sync_ff[9];
	assign pins.por_active = sync_ff[10];

endmodule

`default_nettype wire

// *** design/hsl_pkg.sv ***
// types shared by the strap latch modules
package hsl_pkg;

	// ----------------------------------------
	// capture sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		HSL_ST_RUN = 2'h1,
		HSL_ST_CAPTURE = 2'h2
	} hsl_state_type;

	// ----------------------------------------
	// decoded port 0 operating mode
	// ----------------------------------------
	typedef enum logic [3:0] {
		HSL_P0_MII_MAC = 4'h1,
		HSL_P0_MII_PHY = 4'h2,
		HSL_P0_RMII_PHY = 4'h4,
		HSL_P0_RSVD = 4'h8
	} hsl_p0_mode_type;

endpackage

// *** design/hsl_strap_latch.sv ***
// hard strap latch with decode outputs and an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none

`include "hsl_map.svh"

// Contract
// [R1] capture only on power-on or pin reset
// [R2] values come from pins, never overridden
// [R3] straps drive outputs or register defaults
// [R4] management strap 01 mdio, 10 i2c
// [R5] port0 select 00 mac, 01 phy, 10 rmii
// [R6] three mode pins fold to port0 select
// [R7] refclk direction default from mode pin 1
// [R8] clock drive default from mode pin 0
// [R9] high-rate enable default from mode pin 1
// [R10] address strap picks management addresses
// [R11] prom size strap picks address range
// [R12] polarity 1 supply-tied, 0 ground-tied led
// [R13] each led pin yields two straps
// [R14] latched values hold until next capture
module hsl_strap_latch
	import hsl_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic por_req,
	input wire logic external_reset_n,
	input wire logic led5_addr_pin,
	input wire logic led4_mgmt_hi_pin,
	input wire logic led3_mgmt_lo_pin,
	input wire logic led2_promsize_pin,
	input wire logic led1_xover2_pin,
	input wire logic led0_xover1_pin,
	input wire logic [2:0] port0_mode_pins,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic extended_mdio_mgmt,
	output logic i2c_mgmt,
	output logic mgmt_reserved,
	output logic [1:0] port0_iface_select,
	output logic [3:0] port0_mode,
	output logic port0_refclk_direction,
	output logic port0_clk_drive_level,
	output logic port0_hirate_en,
	output logic phy_addr_select,
	output logic prom_size_large,
	output logic xover2_enable,
	output logic xover1_enable,
	output logic [5:0] led_active_high,
	output logic strap_capturing
);

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	hsl_pin_if pin_bus ();

	hsl_pin_sync #(
		.NUM_BITS(11)
	) u_pin_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.raw_in({por_req, external_reset_n, port0_mode_pins, led5_addr_pin,
			led4_mgmt_hi_pin, led3_mgmt_lo_pin, led2_promsize_pin,
			led1_xover2_pin, led0_xover1_pin}),
		.pins(pin_bus.sync_side)
	);

	// ----------------------------------------
	// capture sequencer
	// ----------------------------------------
	hsl_state_type state_ff;
	hsl_state_type nxt_state;
	logic capture_req;
	logic captured_ff;

	// sys_rst alone is not a strap event
	assign capture_req = pin_bus.ext_rst_active | pin_bus.por_active; // R1

	always_comb begin
		case (state_ff)
			HSL_ST_RUN: begin
				nxt_state = capture_req ? HSL_ST_CAPTURE : HSL_ST_RUN;
			end
			HSL_ST_CAPTURE: begin
				nxt_state = capture_req ? HSL_ST_CAPTURE : HSL_ST_RUN;
			end
			default: begin
				nxt_state = HSL_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff <= HSL_ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strap_capturing <= 1'b0;
		end else begin
			strap_capturing <= (nxt_state == HSL_ST_CAPTURE);
		end
	end

	// ----------------------------------------
	// raw strap latches
	// ----------------------------------------
	// these are not cleared by sys_rst: a plain system reset must keep what
	// the last power-on or pin reset captured
	logic [5:0] led_strap_ff;
	logic [2:0] mode_strap_ff;

	always_ff @(posedge clock) begin
		if (state_ff == HSL_ST_CAPTURE) begin // R1
			led_strap_ff <= pin_bus.led_pins; // R2 R13
			mode_strap_ff <= pin_bus.mode_pins; // R2
		end
	end // R14

	// kept across sys_rst like the raw latches, so decode outputs reload
	// the held straps after a plain system reset
	always_ff @(posedge clock) begin
		if (state_ff == HSL_ST_CAPTURE) begin // R14
			captured_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// strap decode
	// ----------------------------------------
	logic [1:0] mgmt_code;
	logic [1:0] nxt_iface;
	hsl_p0_mode_type nxt_p0_mode;

	assign mgmt_code = led_strap_ff[4:3]; // R13

	always_comb begin
		if (mode_strap_ff == 3'h0) begin // R6
			nxt_iface = `HSL_IFACE_MII_MAC;
		end else if (!mode_strap_ff[2]) begin
			nxt_iface = `HSL_IFACE_MII_PHY;
		end else if (mode_strap_ff != `HSL_PINS_ALL_ONES) begin
			nxt_iface = `HSL_IFACE_RMII_PHY;
		end else begin
			nxt_iface = `HSL_IFACE_RSVD;
		end
	end

	always_comb begin
		case (nxt_iface) // R5
			`HSL_IFACE_MII_MAC: begin
				nxt_p0_mode = HSL_P0_MII_MAC;
			end
			`HSL_IFACE_MII_PHY: begin
				nxt_p0_mode = HSL_P0_MII_PHY;
			end
			`HSL_IFACE_RMII_PHY: begin
				nxt_p0_mode = HSL_P0_RMII_PHY;
			end
			default: begin
				nxt_p0_mode = HSL_P0_RSVD;
			end
		endcase
	end

	// decode outputs are registered so they leave the block from flops
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			extended_mdio_mgmt <= 1'b0;
			i2c_mgmt <= 1'b0;
			mgmt_reserved <= 1'b0;
		end else if (captured_ff) begin
			extended_mdio_mgmt <= (mgmt_code == `HSL_MGMT_EXT_MDIO); // R4
			i2c_mgmt <= (mgmt_code == `HSL_MGMT_I2C); // R4
			mgmt_reserved <= (mgmt_code != `HSL_MGMT_EXT_MDIO) &&
				(mgmt_code != `HSL_MGMT_I2C); // R4
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port0_iface_select <= `HSL_IFACE_MII_MAC;
			port0_mode <= HSL_P0_MII_MAC;
		end else if (captured_ff) begin
			port0_iface_select <= nxt_iface; // R3 R5
			port0_mode <= nxt_p0_mode; // R5
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			phy_addr_select <= 1'b0;
			prom_size_large <= 1'b0;
			xover2_enable <= 1'b0;
			xover1_enable <= 1'b0;
			led_active_high <= 6'h00;
		end else if (captured_ff) begin
			phy_addr_select <= led_strap_ff[5]; // R10 R13
			prom_size_large <= led_strap_ff[2]; // R11 R13
			xover2_enable <= led_strap_ff[1]; // R13
			xover1_enable <= led_strap_ff[0]; // R13
			led_active_high <= led_strap_ff; // R12
		end
	end

	// ----------------------------------------
	// virtual phy special control register
	// ----------------------------------------
	// defaults reload on every system reset and during capture; software
	// may override afterwards, the raw latch stays untouched
	logic wr_fire;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic vs_wr;

	assign vs_wr = wr_fire && (aw_addr_ff == `HSL_VPHY_SPECIAL_CTL_OFS) && w_strb_ff[0];

	always_ff @(posedge clock) begin
		if (sys_rst || state_ff == HSL_ST_CAPTURE) begin // R3
			port0_refclk_direction <= mode_strap_ff[1]; // R7
			port0_clk_drive_level <= mode_strap_ff[0]; // R8
			port0_hirate_en <= mode_strap_ff[1]; // R9
		end else if (vs_wr) begin
			port0_refclk_direction <= w_data_ff[`HSL_VS_REFCLK_DIR_BIT];
			port0_clk_drive_level <= w_data_ff[`HSL_VS_CLK_DRIVE_BIT];
			port0_hirate_en <= w_data_ff[`HSL_VS_HIRATE_BIT];
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	logic aw_have_ff;
	logic w_have_ff;

	assign wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_have_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_ff <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_ff <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr_ff <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_have_ff <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (!aw_have_ff) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			w_have_ff <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_ff <= `HSL_DATA_ZERO;
			w_strb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_ff <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_have_ff <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (!w_have_ff) begin
			s_axi_wready <= 1'b1;
		end
	end

	// strap status and mode status are read-only: writes there are
	// accepted and dropped, so straps stay pin-only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HSL_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_ff == `HSL_STRAP_STATUS_OFS ||
				aw_addr_ff == `HSL_VPHY_SPECIAL_CTL_OFS ||
				aw_addr_ff == `HSL_MODE_STATUS_OFS) ?
				`HSL_RESP_OKAY : `HSL_RESP_DECERR; // R2
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	logic [31:0] nxt_rdata;
	logic [1:0] nxt_rresp;

	always_comb begin
		nxt_rdata = `HSL_DATA_ZERO;
		nxt_rresp = `HSL_RESP_OKAY;
		case (s_axi_araddr)
			`HSL_STRAP_STATUS_OFS: begin
				nxt_rdata[`HSL_ST_LED_POL_LSB +: 6] = led_active_high;
				nxt_rdata[`HSL_ST_MGMT_LSB +: 2] = mgmt_code;
				nxt_rdata[`HSL_ST_IFACE_LSB +: 2] = port0_iface_select;
				nxt_rdata[`HSL_ST_PINS_LSB +: 3] = mode_strap_ff;
				nxt_rdata[`HSL_ST_ADDR_BIT] = phy_addr_select;
				nxt_rdata[`HSL_ST_PROM_BIT] = prom_size_large;
				nxt_rdata[`HSL_ST_XOVER1_BIT] = xover1_enable;
				nxt_rdata[`HSL_ST_XOVER2_BIT] = xover2_enable;
			end
			`HSL_VPHY_SPECIAL_CTL_OFS: begin
				nxt_rdata[`HSL_VS_REFCLK_DIR_BIT] = port0_refclk_direction;
				nxt_rdata[`HSL_VS_CLK_DRIVE_BIT] = port0_clk_drive_level;
				nxt_rdata[`HSL_VS_HIRATE_BIT] = port0_hirate_en;
			end
			`HSL_MODE_STATUS_OFS: begin
				nxt_rdata[`HSL_MS_CAPTURING_BIT] = strap_capturing;
				nxt_rdata[`HSL_MS_CAPTURED_BIT] = captured_ff;
				nxt_rdata[`HSL_MS_MGMT_RSVD_BIT] = mgmt_reserved;
				nxt_rdata[`HSL_MS_IFACE_RSVD_BIT] = port0_mode[3];
			end
			default: begin
				nxt_rresp = `HSL_RESP_DECERR;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `HSL_DATA_ZERO;
			s_axi_rresp <= `HSL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// *** test/hsl_strap_board.sv ***
// board model: pull resistors on the strap pins, then led and interface activity
`timescale 1ns/10ps
`default_nettype none

module hsl_strap_board (
	input wire logic clock,
	input wire logic strap_phase,
	input wire logic [8:0] strap_value,
	output logic [5:0] led_pins,
	output logic [2:0] mode_pins
);
	logic [1:0] hold_ff = 2'h0;
	logic [8:0] duty_ff = 9'h000;

	// pins leave strap duty a little late, like a driver that enables after reset
	always_ff @(posedge clock) begin
		hold_ff <= strap_phase ? 2'h2 : hold_ff - {1'b0, hold_ff != 2'h0};
	end

	// activity changes every cycle so a stale capture cannot pass unseen
	always_ff @(posedge clock) begin
		duty_ff <= duty_ff + 9'h0B7;
	end

	assign {mode_pins, led_pins} = (strap_phase || hold_ff != 2'h0) ? strap_value : duty_ff;
endmodule

`default_nettype wire

// *** test/hsl_strap_monitor.sv ***
// concurrent checks on the ports of the hard strap latch
`timescale 1ns/10ps
`default_nettype none

module hsl_strap_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic por_req,
	input wire logic external_reset_n,
	input wire logic led5_addr_pin,
	input wire logic led4_mgmt_hi_pin,
	input wire logic led3_mgmt_lo_pin,
	input wire logic led2_promsize_pin,
	input wire logic led1_xover2_pin,
	input wire logic led0_xover1_pin,
	input wire logic [2:0] port0_mode_pins,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic extended_mdio_mgmt,
	input wire logic i2c_mgmt,
	input wire logic mgmt_reserved,
	input wire logic [1:0] port0_iface_select,
	input wire logic [3:0] port0_mode,
	input wire logic port0_refclk_direction,
	input wire logic port0_clk_drive_level,
	input wire logic port0_hirate_en,
	input wire logic phy_addr_select,
	input wire logic prom_size_large,
	input wire logic xover2_enable,
	input wire logic xover1_enable,
	input wire logic [5:0] led_active_high,
	input wire logic strap_capturing
);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	logic [3:0] cap_cnt_ff;
	logic [3:0] pin_cnt_ff;
	logic [3:0] quiet_cnt_ff;
	logic [3:0] req_cnt_ff;
	logic [8:0] pins_ff;
	logic seen_ff = 1'b0;
	logic [8:0] pins;
	logic req;
	logic settled;

	assign pins = {port0_mode_pins, led5_addr_pin, led4_mgmt_hi_pin, led3_mgmt_lo_pin,
		led2_promsize_pin, led1_xover2_pin, led0_xover1_pin};
	assign req = por_req || !external_reset_n;
	// outputs only follow the pins once the synchronisers and the latch have caught up
	assign settled = strap_capturing && cap_cnt_ff >= 4'h4 && pin_cnt_ff >= 4'h6 &&
		pins == pins_ff;

	always_ff @(posedge clock) begin
		pins_ff <= pins;
		if (sys_rst || pins != pins_ff) begin
			pin_cnt_ff <= 4'h0;
		end else begin
			pin_cnt_ff <= pin_cnt_ff + {3'h0, pin_cnt_ff != 4'hF};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || !strap_capturing) begin
			cap_cnt_ff <= 4'h0;
		end else begin
			cap_cnt_ff <= cap_cnt_ff + {3'h0, cap_cnt_ff != 4'hF};
		end
	end

	always_ff @(posedge clock) begin
		seen_ff <= seen_ff || strap_capturing;
		if (sys_rst || req || strap_capturing || !seen_ff) begin
			quiet_cnt_ff <= 4'h0;
		end else begin
			quiet_cnt_ff <= quiet_cnt_ff + {3'h0, quiet_cnt_ff != 4'hF};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || req) begin
			req_cnt_ff <= 4'h0;
		end else begin
			req_cnt_ff <= req_cnt_ff + {3'h0, req_cnt_ff != 4'hF};
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking mon_cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	capture_cause_a: assert property ($rose(strap_capturing) |-> req_cnt_ff <= 4'h4)
		else $error("capture started without a qualifying reset");
	capture_start_a: assert property ($rose(por_req) || $fell(external_reset_n)
		|-> ##[1:6] strap_capturing) else $error("capture did not start");
	hold_latched_a: assert property (quiet_cnt_ff >= 4'h4 |-> $stable({extended_mdio_mgmt,
		i2c_mgmt, mgmt_reserved, port0_iface_select, port0_mode, phy_addr_select,
		prom_size_large, xover2_enable, xover1_enable, led_active_high}))
		else $error("latched strap changed outside capture");
	mgmt_onehot_a: assert property (quiet_cnt_ff >= 4'h4 |-> $onehot({extended_mdio_mgmt,
		i2c_mgmt, mgmt_reserved}) && port0_mode == (4'h1 << port0_iface_select))
		else $error("decoded modes inconsistent");
	mgmt_decode_a: assert property (settled |-> extended_mdio_mgmt ==
		(!led4_mgmt_hi_pin && led3_mgmt_lo_pin) && i2c_mgmt == (led4_mgmt_hi_pin &&
		!led3_mgmt_lo_pin)) else $error("management code decode wrong");
	mode_fold_a: assert property (settled |-> port0_iface_select ==
		((port0_mode_pins == 3'h0) ? 2'h0 : (port0_mode_pins <= 3'h3) ? 2'h1 :
		(port0_mode_pins == 3'h7) ? 2'h3 : 2'h2)) else $error("mode pin fold wrong");
	vphy_default_a: assert property (settled |-> {port0_hirate_en, port0_clk_drive_level,
		port0_refclk_direction} == {port0_mode_pins[1:0], port0_mode_pins[1]})
		else $error("virtual phy default wrong");
	led_pol_a: assert property (settled |-> led_active_high == pins[5:0])
		else $error("led polarity wrong");
	side_straps_a: assert property (settled |-> {phy_addr_select, prom_size_large,
		xover2_enable, xover1_enable} == {pins[5], pins[2], pins[1], pins[0]})
		else $error("shared strap wrong");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

bind hsl_strap_latch hsl_strap_monitor hsl_strap_monitor_inst (.*);

`default_nettype wire

// *** test/testbench.sv ***
// self-checking testbench for the hard strap latch
`timescale 1ns/10ps
`default_nettype none

`include "hsl_map.svh"

module testbench;
	logic clock = 1'b0, sys_rst = 1'b1, por_req = 1'b0, external_reset_n = 1'b1;
	logic [8:0] strap_value = 9'h000;
	wire logic led5_addr_pin, led4_mgmt_hi_pin, led3_mgmt_lo_pin;
	wire logic led2_promsize_pin, led1_xover2_pin, led0_xover1_pin, strap_phase;
	wire logic [2:0] port0_mode_pins;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, port0_iface_select;
	logic [31:0] s_axi_rdata;
	logic extended_mdio_mgmt, i2c_mgmt, mgmt_reserved, port0_refclk_direction;
	logic port0_clk_drive_level, port0_hirate_en, phy_addr_select, prom_size_large;
	logic xover2_enable, xover1_enable, strap_capturing;
	logic [3:0] port0_mode;
	logic [5:0] led_active_high;
	logic [8:0] straps [8] = '{9'h000, 9'h04B, 9'h095, 9'h0DE, 9'h12A, 9'h161, 9'h1BF, 9'h1F4};
	int failures = 0;
	int num_checks = 0;

	assign strap_phase = por_req || !external_reset_n;
	always #5 clock = ~clock;

	hsl_strap_latch hsl_strap_latch_inst (.*);
	hsl_strap_board hsl_strap_board_inst (.clock(clock), .strap_phase(strap_phase),
		.strap_value(strap_value), .led_pins({led5_addr_pin, led4_mgmt_hi_pin,
		led3_mgmt_lo_pin, led2_promsize_pin, led1_xover2_pin, led0_xover1_pin}),
		.mode_pins(port0_mode_pins));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= addr;
		s_axi_wdata <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) failures++;
	endtask

	task automatic axi_read(input logic [7:0] addr, output logic [33:0] resp_data);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		resp_data = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'b0;
		if (n >= 50) failures++;
	endtask

	function automatic logic [1:0] fold(input logic [2:0] m);
		return (m == 3'h0) ? 2'h0 : (m <= 3'h3) ? 2'h1 : (m == 3'h7) ? 2'h3 : 2'h2;
	endfunction

	task automatic capture(input logic [8:0] value, input logic by_pin);
		@(posedge clock);
		strap_value <= value;
		external_reset_n <= !by_pin;
		por_req <= !by_pin;
		repeat (12) @(posedge clock);
		external_reset_n <= 1'b1;
		por_req <= 1'b0;
		repeat (10) @(posedge clock);
	endtask

	task automatic check_straps(input logic [8:0] v);
		logic [1:0] sel;
		logic [33:0] rd;
		sel = fold(v[8:6]);
		check({extended_mdio_mgmt, i2c_mgmt, mgmt_reserved},
			{v[4:3] == 2'h1, v[4:3] == 2'h2, v[4] == v[3]});
		check({port0_iface_select, port0_mode}, {sel, 4'h1 << sel});
		check({port0_refclk_direction, port0_clk_drive_level, port0_hirate_en},
			{v[7], v[6], v[7]});
		check({phy_addr_select, prom_size_large, xover2_enable, xover1_enable, led_active_high},
			{v[5], v[2], v[1], v[0], v[5:0]});
		axi_read(`HSL_STRAP_STATUS_OFS, rd);
		check(rd, {`HSL_RESP_OKAY, 8'h00, v[1], v[0], v[2], v[5], 1'b0, v[8:6], 2'h0, sel,
			2'h0, v[4:3], 2'h0, v[5:0]});
		axi_read(`HSL_VPHY_SPECIAL_CTL_OFS, rd);
		check(rd, {`HSL_RESP_OKAY, 29'h0, v[7], v[6], v[7]});
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [33:0] rd;
		logic [1:0] resp;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			capture(straps[i], i[0]);
			check_straps(straps[i]);
		end
		$display("test capture done");
		// a system reset alone must not take new straps from the busy pins
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clock);
		check_straps(straps[7]);
		$display("test system reset done");
		axi_write(`HSL_STRAP_STATUS_OFS, 32'hFFFF_FFFF, resp);
		check(resp, `HSL_RESP_OKAY);
		axi_write(`HSL_MODE_STATUS_OFS, 32'hFFFF_FFFF, resp);
		axi_read(`HSL_MODE_STATUS_OFS, rd);
		check(rd, {`HSL_RESP_OKAY, 32'h0000_000A});
		check_straps(straps[7]);
		axi_write(`HSL_VPHY_SPECIAL_CTL_OFS, 32'h0000_0002, resp);
		axi_read(`HSL_VPHY_SPECIAL_CTL_OFS, rd);
		check(rd, {`HSL_RESP_OKAY, 32'h0000_0002});
		check({port0_refclk_direction, port0_clk_drive_level, port0_hirate_en}, 3'h2);
		axi_write(8'h0C, 32'h0000_0001, resp);
		check(resp, `HSL_RESP_DECERR);
		axi_read(8'h0C, rd);
		check(rd, {`HSL_RESP_DECERR, `HSL_DATA_ZERO});
		capture(straps[2], 1'b1);
		check_straps(straps[2]);
		$display("test registers done");
		complete_run();
	end

	initial begin
		#100000;
		failures++;
		complete_run();
	end
endmodule

`default_nettype wire
